//--- inc/exc_regs.svh
// Register offsets, field positions, reset values and timing counts of the
// exception and low-power controller.
// Assumes inclusion by bare name from the package and the design file.
`ifndef EXC_REGS_SVH
`define EXC_REGS_SVH

// ----------------------------------------------------------------------
// Register byte offsets on the AXI4-Lite slave.
// ----------------------------------------------------------------------
`define EXC_OFS_PEND_LOW 8'h00
`define EXC_OFS_PEND_MID 8'h04
`define EXC_OFS_PEND_HIGH 8'h08
`define EXC_OFS_ENABLE 8'h0C
`define EXC_OFS_BRK_STATUS 8'h10
`define EXC_OFS_BRK_CTRL 8'h14
`define EXC_OFS_CONFIG_ONE 8'h18
`define EXC_OFS_VECTOR 8'h1C

// ----------------------------------------------------------------------
// Field positions and reset values.
// ----------------------------------------------------------------------
`define EXC_BIT_BRK_WAIT 1
`define EXC_BIT_BRK_CLR_EN 7
`define EXC_BIT_SHORT_REC 7
`define EXC_ENABLE_RST 16'h0000
`define EXC_CONFIG_RST 8'h00

// ----------------------------------------------------------------------
// Vector addresses, timing counts and bus response codes.
// ----------------------------------------------------------------------
`define EXC_VEC_RESET 16'hFFFE
`define EXC_VEC_SWTRAP 16'hFFFC
`define EXC_VEC_FLAG1 16'hFFFA
`define EXC_REC_LONG 13'h1000
`define EXC_REC_SHORT 13'h0020
`define EXC_AXI_OKAY 2'h0
`define EXC_AXI_SLVERR 2'h2

`endif

//--- inc/exc_pkg.sv
// Types shared by the exception and low-power controller.
// Assumes the constants header is on the include path.
package exc_pkg;
	`include "exc_regs.svh"

	// Sequencer states of the controller.
	typedef enum logic [2:0] {
		EXC_RUN,
		EXC_STACK,
		EXC_WAIT,
		EXC_STOP,
		EXC_RECOVER
	} exc_state_t;

	// Request from the CPU core at an instruction boundary.
	typedef struct packed {
		logic boundary;
		logic mask_bit;
		logic sw_trap;
		logic wait_op;
		logic stop_op;
		logic handler_done;
	} exc_cpu_req_t;

	// Answer to the CPU core.
	typedef struct packed {
		logic take;
		logic set_mask;
		logic clear_mask;
		logic stack_h;
		logic pc_minus_one;
		logic cpu_clk_en;
		logic clkgen_en;
		logic [15:0] vector;
	} exc_cpu_ans_t;

	// All state of the controller.
	typedef struct packed {
		exc_state_t state;
		logic latched;
		logic [15:0] vector;
		logic pc_minus_one;
		logic [15:0] enable;
		logic brk_wait;
		logic brk_clr_en;
		logic short_rec;
		logic [12:0] rec_cnt;
		logic [15:1] pend_s1;
		logic [15:1] pend_s2;
		logic brk_s1;
		logic brk_s2;
		logic awdone;
		logic wdone;
		logic [7:0] waddr;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} exc_state_all_t;
endpackage

//--- rtl/exc_ctrl.sv
// Exception arbitration and low-power sequencing for a small CPU core.
// Assumes AXI4-Lite software access on aclk and asynchronous request pins.
// Operation
// - Interrupt entry stacks registers, sets mask
// - Latch and arbitrate, give vector code
// - Latched request holds until serviced
// - Never abort instruction in progress
// - Take only if unmasked and enabled
// - Highest priority first, rest stay pending
// - High index register is not stacked
// - Software trap ignores the mask
// - Software trap stacks PC, hardware PC-1
// - Three read-only pending registers, bits zero
// - Fixed priority, vectors FFFA down to FFDE
// - Resets top priority, bypass arbitration
// - Break forces software trap vector
// - Break protects flags unless clear enabled
// - Flag cleared in break stays cleared
// - Two-step clears protected across break
// - Low-power ops clear mask, stop CPU
// - Wait keeps peripherals, stack next cycle
// - Wait ends on enabled request, reset or break
// - Stop halts clocks, stack after recovery
// - Recovery 4096 cycles, or 32 short
// - Counter held reset, then times recovery
// - Break clear enable is read-write
`timescale 1ns/1ps
`include "exc_regs.svh"

module exc_ctrl
	import exc_pkg::*;
(
	// Clock and synchronous active-low reset.
	input wire logic aclk,
	input wire logic aresetn,
	// AXI4-Lite write address and data.
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// AXI4-Lite write response.
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read.
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Peripheral request pins, flag 1 to 15, and break request.
	input wire logic [15:1] irq_pins,
	input wire logic break_req,
	// CPU core request and answer.
	input wire exc_cpu_req_t cpu_req,
	output exc_cpu_ans_t cpu_ans,
	// Break state protection for peripheral status flags.
	output logic flag_clear_allow
);

	// ------------------------------------------------------------------
	// State register and next value.
	// ------------------------------------------------------------------
	exc_state_all_t s_q; // Registered state.
	exc_state_all_t s_d; // Next state.
	logic [15:1] eligible; // Pending and enabled requests.
	logic [15:0] hw_vector; // Vector of the winning request.
	logic hw_any; // Some request may be taken.
	logic in_break; // Break request seen after synchronising.
	logic rd_hit; // Read address is mapped.
	logic [31:0] rd_val; // Read value before registering.
	logic wr_go; // Both write halves held.
	logic [12:0] rec_len; // Selected recovery length.

	// ------------------------------------------------------------------
	// Priority encoder over the enabled flags.
	// ------------------------------------------------------------------

	// Flag 1 wins; each later flag sits two bytes lower in the table.
	always_comb begin
		hw_vector = `EXC_VEC_FLAG1;
		hw_any = 1'b0;
		for (int i = 15; i >= 1; i--) begin
			if (eligible[i]) begin
				hw_any = 1'b1;
				hw_vector = 16'(`EXC_VEC_FLAG1 - 16'(2 * (i - 1)));
			end
		end
	end

	// Only enabled requests take part; the mask is checked later.
	assign eligible = s_q.pend_s2 & s_q.enable[15:1];
	assign in_break = s_q.brk_s2;
	assign rec_len = s_q.short_rec ? `EXC_REC_SHORT : `EXC_REC_LONG;
	assign wr_go = s_q.awdone && s_q.wdone && !s_q.bvalid;

	// ------------------------------------------------------------------
	// Read mux.
	// ------------------------------------------------------------------

	// Pending registers show synchronised request levels, read only.
	always_comb begin
		rd_hit = 1'b1;
		rd_val = 32'h0000_0000;
		case (s_axi_araddr)
			`EXC_OFS_PEND_LOW: rd_val[7:2] = s_q.pend_s2[6:1];
			`EXC_OFS_PEND_MID: rd_val[7:0] = s_q.pend_s2[14:7];
			`EXC_OFS_PEND_HIGH: rd_val[0] = s_q.pend_s2[15];
			`EXC_OFS_ENABLE: rd_val[15:0] = s_q.enable;
			`EXC_OFS_BRK_STATUS: rd_val[`EXC_BIT_BRK_WAIT] = s_q.brk_wait;
			`EXC_OFS_BRK_CTRL: rd_val[`EXC_BIT_BRK_CLR_EN] = s_q.brk_clr_en;
			`EXC_OFS_CONFIG_ONE: rd_val[`EXC_BIT_SHORT_REC] = s_q.short_rec;
			`EXC_OFS_VECTOR: rd_val[15:0] = s_q.vector;
			default: rd_hit = 1'b0;
		endcase
	end

	// ------------------------------------------------------------------
	// Next-state logic.
	// ------------------------------------------------------------------

	// Bus slave, synchronisers and the exception sequencer.
	always_comb begin
		s_d = s_q;
		// Two-flop synchronisers for pins from outside the clock domain.
		s_d.pend_s1 = irq_pins;
		s_d.pend_s2 = s_q.pend_s1;
		s_d.brk_s1 = break_req;
		s_d.brk_s2 = s_q.brk_s1;
		// Write channels are taken independently.
		if (s_axi_awvalid && s_axi_awready) begin
			s_d.awdone = 1'b1;
			s_d.waddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			s_d.wdone = 1'b1;
			s_d.wdata = s_axi_wdata;
			// Strobes belong to the data half and may change once it is taken.
			s_d.wstrb = s_axi_wstrb;
		end
		if (wr_go) begin
			s_d.awdone = 1'b0;
			s_d.wdone = 1'b0;
			s_d.bvalid = 1'b1;
			s_d.bresp = `EXC_AXI_OKAY;
			case (s_q.waddr)
				`EXC_OFS_ENABLE: begin
					if (s_q.wstrb[0])
						s_d.enable[7:0] = s_q.wdata[7:0];
					if (s_q.wstrb[1])
						s_d.enable[15:8] = s_q.wdata[15:8];
				end
				`EXC_OFS_BRK_STATUS: begin
					// Software clears the break wait flag by writing zero.
					if (s_q.wstrb[0] && !s_q.wdata[`EXC_BIT_BRK_WAIT])
						s_d.brk_wait = 1'b0;
				end
				`EXC_OFS_BRK_CTRL: begin
					if (s_q.wstrb[0])
						s_d.brk_clr_en = s_q.wdata[`EXC_BIT_BRK_CLR_EN];
				end
				`EXC_OFS_CONFIG_ONE: begin
					if (s_q.wstrb[0])
						s_d.short_rec = s_q.wdata[`EXC_BIT_SHORT_REC];
				end
				`EXC_OFS_PEND_LOW, `EXC_OFS_PEND_MID, `EXC_OFS_PEND_HIGH,
				`EXC_OFS_VECTOR: begin
					// Read-only registers ignore writes.
				end
				default: s_d.bresp = `EXC_AXI_SLVERR;
			endcase
		end
		if (s_q.bvalid && s_axi_bready)
			s_d.bvalid = 1'b0;
		if (s_axi_arvalid && s_axi_arready) begin
			s_d.rvalid = 1'b1;
			s_d.rdata = rd_val;
			s_d.rresp = rd_hit ? `EXC_AXI_OKAY : `EXC_AXI_SLVERR;
		end else if (s_q.rvalid && s_axi_rready) begin
			s_d.rvalid = 1'b0;
		end
		// Sequencer.
		case (s_q.state)
			EXC_RUN: begin
				// Act only at instruction boundaries.
				if (cpu_req.boundary) begin
					if (in_break || cpu_req.sw_trap) begin
						// Break and trap are taken whatever the mask.
						s_d.latched = 1'b1;
						s_d.vector = `EXC_VEC_SWTRAP;
						s_d.pc_minus_one = 1'b0;
						s_d.state = EXC_STACK;
					end else if (hw_any && !cpu_req.mask_bit) begin
						s_d.latched = 1'b1;
						s_d.vector = hw_vector;
						s_d.pc_minus_one = 1'b1;
						s_d.state = EXC_STACK;
					end else if (cpu_req.wait_op) begin
						s_d.state = EXC_WAIT;
					end else if (cpu_req.stop_op) begin
						s_d.rec_cnt = 13'h0000;
						s_d.state = EXC_STOP;
					end
				end
			end
			EXC_STACK: begin
				// Latched entry holds until the handler returns.
				s_d.state = EXC_RUN;
			end
			EXC_WAIT: begin
				if (in_break) begin
					s_d.brk_wait = 1'b1;
					s_d.latched = 1'b1;
					s_d.vector = `EXC_VEC_SWTRAP;
					s_d.pc_minus_one = 1'b0;
					s_d.state = EXC_STACK;
				end else if (hw_any) begin
					// Stacking starts in the next cycle.
					s_d.latched = 1'b1;
					s_d.vector = hw_vector;
					s_d.pc_minus_one = 1'b1;
					s_d.state = EXC_STACK;
				end
			end
			EXC_STOP: begin
				s_d.rec_cnt = 13'h0000;
				if (in_break || hw_any)
					s_d.state = EXC_RECOVER;
			end
			EXC_RECOVER: begin
				s_d.rec_cnt = s_q.rec_cnt + 13'h0001;
				if (s_q.rec_cnt == rec_len - 13'h0001) begin
					// Recovery elapsed; arbitrate afresh.
					s_d.latched = 1'b1;
					s_d.state = EXC_STACK;
					if (in_break) begin
						s_d.vector = `EXC_VEC_SWTRAP;
						s_d.pc_minus_one = 1'b0;
					end else begin
						s_d.vector = hw_vector;
						s_d.pc_minus_one = 1'b1;
					end
				end
			end
			default: s_d.state = EXC_RUN;
		endcase
		// Handler return frees the latch so others may follow.
		if (cpu_req.handler_done && s_q.state == EXC_RUN)
			s_d.latched = 1'b0;
		// Break wait set wins over a clearing write.
		if (s_q.state == EXC_WAIT && in_break)
			s_d.brk_wait = 1'b1;
	end

	// ------------------------------------------------------------------
	// State register.
	// ------------------------------------------------------------------

	// Reset bypasses arbitration and points the core at the reset vector.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_q <= '0;
			s_q.state <= EXC_RUN;
			s_q.vector <= `EXC_VEC_RESET;
			s_q.enable <= `EXC_ENABLE_RST;
			s_q.short_rec <= 1'b0;
		end else begin
			s_q <= s_d;
		end
	end

	// ------------------------------------------------------------------
	// Outputs.
	// ------------------------------------------------------------------
	assign s_axi_awready = !s_q.awdone;
	assign s_axi_wready = !s_q.wdone;
	assign s_axi_bvalid = s_q.bvalid;
	assign s_axi_bresp = s_q.bresp;
	assign s_axi_arready = !s_q.rvalid;
	assign s_axi_rvalid = s_q.rvalid;
	assign s_axi_rdata = s_q.rdata;
	assign s_axi_rresp = s_q.rresp;

	// One-cycle entry pulse: stack everything but H and set the mask.
	assign cpu_ans.take = (s_q.state == EXC_STACK);
	assign cpu_ans.set_mask = (s_q.state == EXC_STACK);
	assign cpu_ans.stack_h = 1'b0;
	assign cpu_ans.pc_minus_one = s_q.pc_minus_one;
	assign cpu_ans.vector = s_q.vector;
	// Low-power ops clear the mask so a request can wake the core.
	assign cpu_ans.clear_mask = (s_q.state == EXC_WAIT) ||
		(s_q.state == EXC_STOP);
	assign cpu_ans.cpu_clk_en = (s_q.state == EXC_RUN) ||
		(s_q.state == EXC_STACK);
	assign cpu_ans.clkgen_en = (s_q.state != EXC_STOP);
	// Flags may clear outside break, or in break with clear enabled.
	// A cleared flag simply stays cleared; a two-step clear pending
	// from before break is also held back here.
	assign flag_clear_allow = !in_break || s_q.brk_clr_en;

endmodule // exc_ctrl

//--- testbench/exc_ctrl_chk.sv
// Port checker for the exception controller.
// Assumes it is bound to exc_ctrl by the statement at the foot.
`timescale 1ns/1ps
module exc_ctrl_chk
	import exc_pkg::*;
(
	// Clock and reset.
	input wire logic aclk,
	input wire logic aresetn,
	// Watched requests and answers.
	input wire logic break_req,
	input wire exc_cpu_req_t cpu_req,
	input wire exc_cpu_ans_t cpu_ans
);
	// -------------------------------------------------------------
	// Helper logic.
	// -------------------------------------------------------------
	// Set while a stop is outstanding.
	logic stop_q;
	logic stop_d;
	// Cycles since the clock generator came back.
	logic [12:0] rec_q;
	logic [12:0] rec_d;
	// Break was low at the previous sample.
	logic calm;
	always_comb begin
		stop_d = !cpu_ans.clkgen_en | (stop_q & !cpu_ans.take);
		rec_d = rec_q;
		if (!cpu_ans.clkgen_en) begin
			rec_d = 13'h0000;
		end else if (stop_q && rec_q != 13'h1FFF) begin
			rec_d = rec_q + 13'h0001;
		end
	end
	// Registers the stop and recovery helpers; reset clears them.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			stop_q <= 1'b0;
			rec_q <= 13'h0000;
		end else begin
			stop_q <= stop_d;
			rec_q <= rec_d;
		end
	end
	// -------------------------------------------------------------
	// Assertions.
	// -------------------------------------------------------------
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	always_ff @(posedge aclk) begin
		calm <= !break_req;
	end
	AST_TAKE_ONE: assert property (cpu_ans.take |=> !cpu_ans.take)
		else $error("take lasted more than one cycle");
	AST_TAKE_MASK: assert property (cpu_ans.take |-> cpu_ans.set_mask)
		else $error("entry without mask set");
	AST_NO_HIGH_IDX: assert property (!cpu_ans.stack_h)
		else $error("high index stacked");
	AST_SW_VEC: assert property (cpu_req.boundary && cpu_req.sw_trap
		&& !cpu_ans.take && cpu_ans.cpu_clk_en && calm && !break_req
		&& !$past(break_req, 2) |=> cpu_ans.take
		&& cpu_ans.vector == 16'hFFFC && !cpu_ans.pc_minus_one)
		else $error("software trap not taken");
	AST_HW_PCM1: assert property (cpu_ans.take
		&& cpu_ans.vector < 16'hFFFC |-> cpu_ans.pc_minus_one)
		else $error("hardware entry without pc minus one");
	AST_VEC_RANGE: assert property (cpu_ans.take
		|-> cpu_ans.vector >= 16'hFFDE && !cpu_ans.vector[0])
		else $error("vector outside table");
	AST_MASKED: assert property (cpu_req.boundary && cpu_req.mask_bit
		&& !cpu_req.sw_trap && !cpu_req.wait_op && !cpu_req.stop_op
		&& calm && !break_req && !$past(break_req, 2) |=> !cpu_ans.take)
		else $error("masked request taken");
	AST_STOP_CLK: assert property (!cpu_ans.clkgen_en |-> !cpu_ans.cpu_clk_en)
		else $error("cpu clocked while generator off");
	AST_STOP_REC: assert property (cpu_ans.take && stop_q
		|-> rec_q >= 13'h0020)
		else $error("stop recovery too short");
	AST_RESET_VEC: assert property (disable iff (1'b0) !aresetn
		|=> cpu_ans.vector == 16'hFFFE && !cpu_ans.take)
		else $error("reset vector not selected");
endmodule // exc_ctrl_chk

bind exc_ctrl exc_ctrl_chk exc_ctrl_chk_i (.aclk, .aresetn, .break_req,
	.cpu_req, .cpu_ans);

//--- testbench/exc_cpu_model.sv
// Behavioural CPU core issuing instruction boundaries.
// Assumes the controller answers on the same clock.
`timescale 1ns/1ps
module exc_cpu_model
	import exc_pkg::*;
(
	// Clock and controller answer.
	input wire logic aclk,
	input wire exc_cpu_ans_t cpu_ans,
	// Request to the controller.
	output exc_cpu_req_t cpu_req
);
	// Interrupt mask bit of the condition codes.
	logic mask_q = 1'b0;
	initial cpu_req = '0;
	// Entry sets the mask; low-power entry clears it.
	always @(posedge aclk) begin
		if (cpu_ans.set_mask) begin
			mask_q <= 1'b1;
		end else if (cpu_ans.clear_mask) begin
			mask_q <= 1'b0;
		end
	end
	// One boundary cycle; a return restores a clear mask.
	task automatic op(input logic sw, input logic wt, input logic st,
		input logic dn);
		@(posedge aclk);
		// An entry pulse at this very edge has set the mask already.
		cpu_req <= '{1'b1, (mask_q | cpu_ans.set_mask) & !dn, sw, wt, st, dn};
		if (dn) mask_q <= 1'b0;
		@(posedge aclk);
		cpu_req <= '0;
	endtask
endmodule // exc_cpu_model

//--- testbench/test_exc_ctrl.sv
// Self-checking bench for the exception controller.
// Assumes register offsets as the designer placed them.
`timescale 1ns/1ps
module test_exc_ctrl
	import exc_pkg::*;
;
	// Bus, pins and bookkeeping.
	logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0;
	logic arvalid = 0, rready = 0, brk = 0, fca;
	logic awready, wready, bvalid, arready, rvalid;
	logic [7:0] awaddr = 0, araddr = 0;
	logic [31:0] wdata = 0, rdata, rd;
	logic [1:0] bresp, rresp, rs;
	logic [15:1] pins = 0;
	exc_cpu_req_t req;
	exc_cpu_ans_t ans;
	int mismatches = 0, checks = 0, cyc = 0;
	initial forever #2 aclk = ~aclk;
	exc_ctrl exc_ctrl_i (.aclk, .aresetn, .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .irq_pins(pins), .break_req(brk),
		.cpu_req(req), .cpu_ans(ans), .flag_clear_allow(fca));
	exc_cpu_model exc_cpu_model_i (.aclk, .cpu_ans(ans), .cpu_req(req));
	// -------------------------------------------------------------
	// Shared tasks.
	// -------------------------------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			mismatches++;
			$display("Error %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task automatic final_report();
		if (mismatches == 0 && checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	// Hang guard: the whole run needs well under this many cycles.
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			mismatches++;
			final_report();
		end
	end
	// Register write; each half is released when it is taken.
	task automatic axw(input logic [7:0] a, input logic [31:0] d);
		@(posedge aclk);
		{awaddr, wdata, awvalid, wvalid, bready} <= {a, d, 3'b111};
		do begin
			@(posedge aclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (!bvalid);
		rs = bresp;
		bready <= 1'b0;
	endtask
	// Register read; data taken at the edge rvalid is seen.
	task automatic axr(input logic [7:0] a);
		@(posedge aclk);
		{araddr, arvalid, rready} <= {a, 2'b11};
		do begin
			@(posedge aclk);
			if (arready) arvalid <= 1'b0;
		end while (!rvalid);
		{rd, rs} = {rdata, rresp};
		rready <= 1'b0;
	endtask
	// Boundary, then the answer one edge later.
	task automatic op(input logic [3:0] f);
		exc_cpu_model_i.op(f[3], f[2], f[1], f[0]);
		#1;
	endtask
	// Waits for an entry, counting cycles with the generator running.
	task automatic wtake(output int n);
		n = 0;
		while (ans.take !== 1'b1 && cyc < 29000) begin
			@(posedge aclk);
			#1;
			n += int'(ans.clkgen_en);
		end
	endtask
	// -------------------------------------------------------------
	// Scenarios.
	// -------------------------------------------------------------
	task automatic t_regs();
		axr(8'h0C);
		chk(rd, 32'h0000_0000);
		axr(8'h1C);
		chk(rd, 32'h0000_FFFE);
		pins <= 15'h7FFF;
		axw(8'h00, 32'hFFFF_FFFF);
		chk(rs, 2'h0);
		axr(8'h00);
		chk(rd, 32'h0000_00FC);
		axr(8'h04);
		chk(rd, 32'h0000_00FF);
		axr(8'h08);
		chk(rd, 32'h0000_0001);
		pins <= 15'h0000;
		axw(8'h20, 32'h0000_0000);
		chk(rs, 2'h2);
		axw(8'h14, 32'h0000_0080);
		axr(8'h14);
		chk(rd, 32'h0000_0080);
		axw(8'h14, 32'h0000_0000);
	endtask
	// Every flag alone: vector, masked retry, return.
	task automatic t_flags();
		axw(8'h0C, 32'h0000_FFFE);
		for (int i = 1; i <= 15; i++) begin
			pins <= 15'h0001 << (i - 1);
			repeat (3) @(posedge aclk);
			op(4'h0);
			chk({ans.take, ans.pc_minus_one, ans.vector},
				{2'b11, 16'hFFFA - 16'(2 * (i - 1))});
			op(4'h0);
			chk(ans.take, 1'b0);
			pins <= 15'h0000;
			repeat (3) @(posedge aclk);
			op(4'h1);
		end
	endtask
	// Priority, enables, trap, then break and wait.
	task automatic t_pri();
		int n;
		axw(8'h0C, 32'h0000_0028);
		pins <= 15'h0054;
		repeat (3) @(posedge aclk);
		op(4'h0);
		chk(ans.vector, 16'hFFF6);
		pins <= 15'h0050;
		repeat (3) @(posedge aclk);
		op(4'h1);
		chk({ans.take, ans.vector}, {1'b1, 16'hFFF2});
		op(4'h8);
		chk({ans.take, ans.pc_minus_one, ans.vector}, 18'h2FFFC);
		pins <= 15'h0000;
		brk <= 1'b1;
		repeat (3) @(posedge aclk);
		op(4'h1);
		chk({ans.take, ans.vector}, {1'b1, 16'hFFFC});
		chk(fca, 1'b0);
		axw(8'h14, 32'h0000_0080);
		chk(fca, 1'b1);
		brk <= 1'b0;
		repeat (3) @(posedge aclk);
		op(4'h4);
		repeat (2) @(posedge aclk);
		chk({ans.cpu_clk_en, ans.clkgen_en, exc_cpu_model_i.mask_q},
			3'b010);
		pins <= 15'h0004;
		wtake(n);
		chk({ans.take, ans.vector}, {1'b1, 16'hFFF6});
		pins <= 15'h0000;
		repeat (3) @(posedge aclk);
		op(4'h4);
		brk <= 1'b1;
		wtake(n);
		axr(8'h10);
		chk(rd[1], 1'b1);
		brk <= 1'b0;
		repeat (3) @(posedge aclk);
		op(4'h1);
	endtask
	// Short then long stop recovery.
	task automatic t_stop(input logic s, input int exp);
		int n;
		axw(8'h18, {24'h0, s, 7'h0});
		op(4'h2);
		repeat (2) @(posedge aclk);
		chk(ans.clkgen_en, 1'b0);
		pins <= 15'h0004;
		wtake(n);
		chk(n >= exp && n <= exp + 3, 1'b1);
		pins <= 15'h0000;
		repeat (3) @(posedge aclk);
		op(4'h1);
	endtask
	initial begin
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		t_regs();
		t_flags();
		t_pri();
		t_stop(1'b1, 32);
		t_stop(1'b0, 4096);
		@(posedge aclk);
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		#1;
		chk({ans.cpu_clk_en, ans.vector}, 17'h1FFFE);
		final_report();
	end
endmodule // test_exc_ctrl
